// >>> rtl/itse_pkg.sv
/*
 * Constants for the time code symbol encoder: carrier and symbol timing,
 * symbol kinds, clock quality field layout, frame length.
 * Assumes a 20 MHz reference clock.
 */
package itse_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned CARRIER_HZ = 1000;
	localparam int unsigned CYC_PER_CARRIER = CLK_HZ / CARRIER_HZ;
	localparam int unsigned CARRIERS_PER_SYM = 10;
	localparam int unsigned MARK_ZERO = 2;
	localparam int unsigned MARK_ONE = 5;
	localparam int unsigned MARK_POS = 8;
	localparam int unsigned FRAME_SYMS = 100;
	localparam int unsigned QUAL_FIRST = 71;
	localparam int unsigned QUAL_LAST = 74;
	localparam int unsigned PARITY_POS = 75;
	localparam logic [3:0] QUAL_LOCKED = 4'h0;
	localparam logic [3:0] QUAL_FAILED = 4'hF;

	typedef enum logic [1:0] {
		ITSE_SYM_ZERO = 2'h0,
		ITSE_SYM_ONE = 2'h1,
		ITSE_SYM_POS = 2'h2
	} itse_sym_t;

	typedef enum logic [2:0] {
		ITSE_CODE_B = 3'h1,
		ITSE_CODE_AFNOR = 3'h2,
		ITSE_CODE_IEEE = 3'h4
	} itse_code_t;
endpackage : itse_pkg

// >>> rtl/itse_encoder.sv
/*
 * Time code symbol encoder: takes symbols (zero, one, position marker)
 * through a two-entry buffer and sends each as ten 1 kHz carrier periods
 * on an amplitude-select output and, in parallel, a pulse-width level
 * output. Fills the clock quality field and the parity bit of the
 * IEEE-extended frame.
 * Assumes the symbol source presents frames of 100 symbols, raising
 * SYM_FIRST_IN with the first symbol of each frame.
 */
`timescale 1ns/1ns
`default_nettype none

// How it works
// - level and carrier forms always emitted together
// - quality field follows upstream sync status flag
// - synced once since power-up: field 0000
// - never synced since power-up: field 1111
// - test setting forces quality field zero
// - 1 kHz carrier, ten periods per symbol
// - symbol coded by count of MARK cycles
// - zero: two MARK, eight SPACE
// - one: five MARK, five SPACE
// - position marker: eight MARK, two SPACE
// - one hundred symbols per second
// - quality field at positions 71 to 74
// - parity at 75 over preceding bits
module itse_encoder
	import itse_pkg::*;
#(
	parameter int unsigned CARRIER_CYCLES = CYC_PER_CARRIER
)(
	input wire logic REF_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic [1:0] SYM_IN,
	input wire logic SYM_FIRST_IN,
	input wire logic SYM_VALID_IN,
	output logic SYM_READY_OUT,
	input wire logic [2:0] CODE_SEL_IN,
	input wire logic QUAL_TEST_OFF_IN,
	input wire logic NEVER_SYNCED_IN,
	output logic CARRIER_MARK_OUT,
	output logic CARRIER_PHASE_OUT,
	output logic LEVEL_SHIFT_OUT,
	output logic [6:0] SYM_POS_OUT
);
	localparam int CW = $clog2(CARRIER_CYCLES);

	////////////////////////////////////////////////////////////////////
	// two-entry input buffer
	logic [2:0] buf0_r, buf1_r;
	logic v0_r, v1_r;
	logic take_in, pop;
	logic [2:0] head;

	// take only what the source saw offered: ready is the handshake
	assign take_in = SYM_VALID_IN && SYM_READY_OUT;
	assign head = buf0_r;

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
		begin
			v0_r <= 1'b0;
			v1_r <= 1'b0;
			buf0_r <= 3'h0;
			buf1_r <= 3'h0;
		end
		else
		begin
			if (pop)
			begin
				v0_r <= v1_r || (take_in && v0_r);
				buf0_r <= v1_r ? buf1_r : {SYM_FIRST_IN, SYM_IN};
				v1_r <= v1_r ? (take_in) : 1'b0;
				if (v1_r)
					buf1_r <= {SYM_FIRST_IN, SYM_IN};
				if (!v1_r && take_in && !v0_r)
					v0_r <= 1'b0;
			end
			else if (take_in)
			begin
				if (!v0_r)
				begin
					v0_r <= 1'b1;
					buf0_r <= {SYM_FIRST_IN, SYM_IN};
				end
				else
				begin
					v1_r <= 1'b1;
					buf1_r <= {SYM_FIRST_IN, SYM_IN};
				end
			end
		end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
			SYM_READY_OUT <= 1'b0;
		else
			SYM_READY_OUT <= !(v1_r || (v0_r && take_in && !pop));

	////////////////////////////////////////////////////////////////////
	// carrier timing: one-cycle enable per carrier period
	logic [CW-1:0] cyc_r;
	logic [3:0] per_r;
	logic carrier_end, sym_end;
	logic busy_r;

	assign carrier_end = busy_r && (cyc_r == CW'(CARRIER_CYCLES - 1));
	assign sym_end = carrier_end && (per_r == 4'(CARRIERS_PER_SYM - 1));
	assign pop = v0_r && (!busy_r || sym_end);

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
		begin
			cyc_r <= '0;
			per_r <= 4'h0;
			busy_r <= 1'b0;
		end
		else
		begin
			if (pop || carrier_end)
				cyc_r <= '0;
			else if (busy_r)
				cyc_r <= cyc_r + CW'(1);
			if (pop)
				per_r <= 4'h0;
			else if (carrier_end)
				per_r <= per_r + 4'h1;
			if (pop)
				busy_r <= 1'b1;
			else if (sym_end)
				busy_r <= 1'b0;
		end

	////////////////////////////////////////////////////////////////////
	// frame position, mode latching, field substitution, parity
	logic [6:0] pos_nxt, pos_r;
	logic [2:0] code_r;
	logic test_off_r;
	logic frame_start;
	logic in_qual, at_parity;
	logic [3:0] qual_val;
	logic [1:0] raw_sym, sym_nxt;
	logic par_r;
	logic data_bit;
	logic ieee_mode, ieee_nxt, test_nxt;

	assign frame_start = head[2];
	assign pos_nxt = frame_start ? 7'h00 : pos_r + 7'h01;
	assign ieee_nxt = frame_start ? (CODE_SEL_IN == ITSE_CODE_IEEE)
		: code_r == ITSE_CODE_IEEE;
	assign test_nxt = frame_start ? QUAL_TEST_OFF_IN : test_off_r;
	assign ieee_mode = ieee_nxt;
	assign in_qual = ieee_mode && pos_nxt >= 7'(QUAL_FIRST)
		&& pos_nxt <= 7'(QUAL_LAST);
	assign at_parity = ieee_mode && pos_nxt == 7'(PARITY_POS);
	assign qual_val = (test_nxt || !NEVER_SYNCED_IN)
		? QUAL_LOCKED : QUAL_FAILED;
	assign raw_sym = head[1:0];
	assign sym_nxt = in_qual
		? {1'b0, qual_val[2'(pos_nxt - 7'(QUAL_FIRST))]}
		: at_parity ? {1'b0, par_r} : raw_sym;
	assign data_bit = (sym_nxt == ITSE_SYM_ONE);

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
		begin
			pos_r <= 7'h00;
			code_r <= ITSE_CODE_B;
			test_off_r <= 1'b0;
			par_r <= 1'b0;
		end
		else if (pop)
		begin
			pos_r <= pos_nxt;
			if (frame_start)
			begin
				code_r <= CODE_SEL_IN;
				test_off_r <= QUAL_TEST_OFF_IN;
			end
			par_r <= (frame_start ? 1'b0 : par_r) ^ data_bit;
		end

	////////////////////////////////////////////////////////////////////
	// MARK count per symbol and output drive
	logic [3:0] marks_r, marks_nxt;
	logic mark_now;

	always_comb
	begin
		marks_nxt = 4'(MARK_ZERO);
		unique case (sym_nxt)
			ITSE_SYM_ONE: marks_nxt = 4'(MARK_ONE);
			ITSE_SYM_POS: marks_nxt = 4'(MARK_POS);
			default: marks_nxt = 4'(MARK_ZERO);
		endcase
	end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
			marks_r <= 4'h0;
		else if (pop)
			marks_r <= marks_nxt;

	assign mark_now = busy_r && (per_r < marks_r);

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
		begin
			CARRIER_MARK_OUT <= 1'b0;
			CARRIER_PHASE_OUT <= 1'b0;
			LEVEL_SHIFT_OUT <= 1'b0;
			SYM_POS_OUT <= 7'h00;
		end
		else
		begin
			CARRIER_MARK_OUT <= mark_now;
			LEVEL_SHIFT_OUT <= mark_now;
			CARRIER_PHASE_OUT <= busy_r
				&& (cyc_r < CW'(CARRIER_CYCLES / 2));
			SYM_POS_OUT <= pos_r;
		end

	////////////////////////////////////////////////////////////////////
	// checks
	localparam int unsigned SYM_CYCLES = CARRIER_CYCLES * CARRIERS_PER_SYM;
	logic [31:0] since_pop_r;

	// cycles since the last symbol start, for the length check only
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
			since_pop_r <= 32'h0;
		else if (pop)
			since_pop_r <= 32'h0;
		else
			since_pop_r <= since_pop_r + 32'h1;

	property p_sym_len;
		@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		pop && busy_r |-> since_pop_r == 32'(SYM_CYCLES - 1);
	endproperty
	a_sym_len: assert property (p_sym_len)
		else $error("symbol restarted early");

	property p_mark_first;
		@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		pop && marks_nxt != 4'h0 |=> ##1 CARRIER_MARK_OUT;
	endproperty
	a_mark_first: assert property (p_mark_first)
		else $error("symbol did not open with MARK");

	property p_level_start;
		@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		$rose(LEVEL_SHIFT_OUT) |-> $past(pop, 2);
	endproperty
	a_level_start: assert property (p_level_start)
		else $error("level output rose away from symbol start");

	property p_same_forms;
		@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		CARRIER_MARK_OUT == LEVEL_SHIFT_OUT;
	endproperty
	a_same_forms: assert property (p_same_forms)
		else $error("level and carrier forms differ");

	property p_zero_marks;
		@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		pop && sym_nxt == ITSE_SYM_ZERO |=> marks_r == 4'(MARK_ZERO);
	endproperty
	a_zero_marks: assert property (p_zero_marks)
		else $error("zero symbol MARK count wrong");

	property p_one_marks;
		@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		pop && sym_nxt == ITSE_SYM_ONE |=> marks_r == 4'(MARK_ONE);
	endproperty
	a_one_marks: assert property (p_one_marks)
		else $error("one symbol MARK count wrong");

	property p_pos_marks;
		@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		pop && sym_nxt == ITSE_SYM_POS |=> marks_r == 4'(MARK_POS);
	endproperty
	a_pos_marks: assert property (p_pos_marks)
		else $error("marker MARK count wrong");

	property p_qual_failed;
		@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		pop && in_qual && NEVER_SYNCED_IN && !test_nxt
		|-> sym_nxt == ITSE_SYM_ONE;
	endproperty
	a_qual_failed: assert property (p_qual_failed)
		else $error("quality field not ones");

	property p_qual_zero;
		@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		pop && in_qual && (test_nxt || !NEVER_SYNCED_IN)
		|-> sym_nxt == ITSE_SYM_ZERO;
	endproperty
	a_qual_zero: assert property (p_qual_zero)
		else $error("quality field not zeros");

	property p_mode_hold;
		@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		pop && !frame_start |=> $stable(code_r) && $stable(test_off_r);
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("mode changed inside frame");
endmodule : itse_encoder

`default_nettype wire

// >>> tb/itse_rx_model.sv
/*
 * Receiving-end model: times the MARK run and period of each symbol
 * and counts the carrier periods between symbol starts.
 * Assumes MARK and level outputs of the encoder on one clock.
 */
`timescale 1ns/1ns
`default_nettype none
module itse_rx_model
	import itse_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic mark_in,
	input wire logic level_in,
	input wire logic phase_in,
	output logic done_out,
	output logic [15:0] high_out,
	output logic [15:0] period_out,
	output logic split_out,
	output logic [15:0] carriers_out
);
	logic mark_r;
	logic ph_r;
	logic [15:0] car_r;
	logic [15:0] high_r;
	logic [15:0] per_r;
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			{mark_r, done_out, split_out, ph_r} <= 4'h0;
			{high_r, per_r, high_out, period_out} <= 64'h0;
			{car_r, carriers_out} <= 32'h0;
		end
		else
		begin
			mark_r <= mark_in;
			ph_r <= phase_in;
			done_out <= mark_r && !mark_in;
			if (level_in !== mark_in)
				split_out <= 1'h1;
			if (per_r != 16'h0)
				per_r <= per_r + 16'h1;
			if (phase_in && !ph_r)
				car_r <= car_r + 16'h1;
			if (mark_in && !mark_r)
			begin
				period_out <= per_r;
				per_r <= 16'h1;
				carriers_out <= car_r;
				car_r <= {15'h0, phase_in && !ph_r};
			end
			high_r <= mark_in ? high_r + 16'h1 : 16'h0;
			if (mark_r && !mark_in)
				high_out <= high_r;
		end
	end
endmodule : itse_rx_model
`default_nettype wire

// >>> tb/itse_encoder_bench.sv
/*
 * Bench: five frames under varied code and quality settings.
 * Assumes a shortened carrier of CC clocks.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	fail_count++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module itse_encoder_bench;
	import itse_pkg::*;
	localparam int CC = 4;
	logic REF_CLK_IN, ARST_N_IN, SYM_FIRST_IN, SYM_VALID_IN, SYM_READY_OUT;
	logic [1:0] SYM_IN;
	logic [2:0] CODE_SEL_IN;
	logic QUAL_TEST_OFF_IN, NEVER_SYNCED_IN, CARRIER_MARK_OUT;
	logic CARRIER_PHASE_OUT, LEVEL_SHIFT_OUT, done, split, par;
	logic [6:0] SYM_POS_OUT;
	logic [15:0] hi, per, car;
	logic [31:0] rnd = 32'h11953BC6;
	logic [10:0] exp_q [$];
	logic [10:0] m;
	logic [1:0] d;
	itse_sym_t e;
	itse_code_t code_t [5] = '{ITSE_CODE_IEEE, ITSE_CODE_IEEE,
		ITSE_CODE_IEEE, ITSE_CODE_B, ITSE_CODE_AFNOR};
	logic [4:0] nev_t = 5'h13;
	logic [4:0] tst_t = 5'h02;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	itse_encoder #(.CARRIER_CYCLES(CC)) i_itse_encoder (.REF_CLK_IN,
		.ARST_N_IN, .SYM_IN, .SYM_FIRST_IN, .SYM_VALID_IN, .SYM_READY_OUT,
		.CODE_SEL_IN, .QUAL_TEST_OFF_IN, .NEVER_SYNCED_IN, .CARRIER_MARK_OUT,
		.CARRIER_PHASE_OUT, .LEVEL_SHIFT_OUT, .SYM_POS_OUT);
	itse_rx_model i_itse_rx_model (.clk_in(REF_CLK_IN),
		.arst_n_in(ARST_N_IN), .mark_in(CARRIER_MARK_OUT),
		.level_in(LEVEL_SHIFT_OUT), .phase_in(CARRIER_PHASE_OUT),
		.done_out(done), .high_out(hi), .period_out(per),
		.split_out(split), .carriers_out(car));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic finish_test();
		$display("compared %0d, failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	task automatic send(input logic [1:0] s, input logic f);
		SYM_IN <= s;
		SYM_FIRST_IN <= f;
		SYM_VALID_IN <= 1'b1;
		@(negedge REF_CLK_IN);
		while (SYM_READY_OUT !== 1'b1)
			@(negedge REF_CLK_IN);
		@(posedge REF_CLK_IN);
	endtask : send
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		REF_CLK_IN = 1'b0;
		forever #25 REF_CLK_IN = ~REF_CLK_IN;
	end
	always @(posedge REF_CLK_IN)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fail_count++;
			finish_test();
		end
	end
	always @(posedge REF_CLK_IN)
		if (done)
		begin
			m = exp_q.pop_front();
			`CHK("mark cycles", m[3:0] * CC, hi)
			`CHK("symbol position", m[10:4], SYM_POS_OUT)
			if (per != 16'h0)
			begin
				`CHK("symbol period", 10 * CC, per)
				`CHK("carrier periods", CARRIERS_PER_SYM, car)
			end
		end
	initial
	begin
		ARST_N_IN = 1'b0;
		SYM_IN = 2'h0;
		SYM_FIRST_IN = 1'b0;
		SYM_VALID_IN = 1'b0;
		CODE_SEL_IN = code_t[0];
		NEVER_SYNCED_IN = nev_t[0];
		QUAL_TEST_OFF_IN = tst_t[0];
		par = 1'b0;
		repeat (4) @(posedge REF_CLK_IN);
		ARST_N_IN <= 1'b1;
		@(negedge REF_CLK_IN);
		`CHK("mark after reset", 1'b0, CARRIER_MARK_OUT)
		@(posedge REF_CLK_IN);
		for (int f = 0; f < 5; f++)
			for (int p = 0; p < 100; p++)
			begin
				// next frame's settings, mid-frame
				if (p == 30 && f < 4)
				begin
					CODE_SEL_IN <= code_t[f + 1];
					QUAL_TEST_OFF_IN <= tst_t[f + 1];
				end
				// sync flag is live, so it changes only between frames
				if (p == 0)
					NEVER_SYNCED_IN <= nev_t[f];
				rnd = lfsr(rnd);
				d = (p == 0 || p % 10 == 9) ? 2'h2 : rnd[1:0];
				e = itse_sym_t'(d == 2'h3 ? 2'h0 : d);
				if (p == 0)
					par = 1'b0;
				if (code_t[f] == ITSE_CODE_IEEE && p >= 71 && p <= 74)
					e = itse_sym_t'({1'b0, nev_t[f] & !tst_t[f]});
				if (code_t[f] == ITSE_CODE_IEEE && p == 75)
					e = itse_sym_t'({1'b0, par});
				par = par ^ (e == ITSE_SYM_ONE);
				exp_q.push_back({7'(p), e == ITSE_SYM_ONE ? 4'(MARK_ONE) :
					e == ITSE_SYM_POS ? 4'(MARK_POS) : 4'(MARK_ZERO)});
				send(d, p == 0);
			end
		SYM_VALID_IN <= 1'b0;
		repeat (400)
			if (exp_q.size() != 0)
				@(posedge REF_CLK_IN);
		`CHK("queue left", 0, exp_q.size())
		`CHK("level apart from mark", 1'b0, split)
		finish_test();
	end
endmodule : itse_encoder_bench
`default_nettype wire
